// ===== verilog/meb_pkg.sv
// Purpose: Shared constants and types of the external memory bus sequencer.
// Assumes: One oscillator period is one clk cycle; a bus slot is six cycles.
// Notes: Phase numbers count from zero at the start of each slot.
package meb_pkg;

	localparam logic [2:0]  MEB_PH_LAST     = 3'h5;
	localparam logic [2:0]  MEB_ALE_END     = 3'h2;
	localparam logic [2:0]  MEB_ADDR_END    = 3'h2;
	localparam logic [2:0]  MEB_PROGRAM_STORE_STROBE_N_START  = 3'h2;
	localparam logic [2:0]  MEB_PROGRAM_STORE_STROBE_N_END    = 3'h5;
	localparam logic [2:0]  MEB_RD_END      = 3'h5;
	localparam logic [2:0]  MEB_WR_START    = 3'h1;
	localparam logic [2:0]  MEB_WR_END      = 3'h4;
	localparam logic [15:0] MEB_ROM_LIMIT   = 16'h1000;
	localparam logic [7:0]  MEB_LATCH_RESET = 8'hff;
	localparam logic [2:0]  MEB_VERIFY_P2   = 3'h0;

	typedef enum logic [1:0] {
		MEB_OP_FETCH,
		MEB_OP_READ,
		MEB_OP_WRITE
	} meb_op_t;

	typedef enum logic [2:0] {
		MEB_SLOT_IDLE,
		MEB_SLOT_IFETCH,
		MEB_SLOT_XFETCH,
		MEB_SLOT_DADDR,
		MEB_SLOT_DRD,
		MEB_SLOT_DWR
	} meb_slot_t;

	typedef struct packed {
		meb_op_t     op;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} meb_req_t;

	typedef struct packed {
		logic       is_code;
		logic [7:0] data;
	} meb_resp_t;

	typedef struct packed {
		logic       rst;
		logic       ea;
		logic       ale;
		logic       program_store_strobe_n_n;
		logic [7:0] p0;
		logic [7:0] p1;
		logic [7:0] p2;
	} meb_pins_t;

	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
	} meb_port_t;

endpackage

// ===== verilog/meb_rom.sv
// Purpose: Internal program store, four kilobytes, registered read data.
// Assumes: Contents are fixed at manufacture.
// Notes: The pattern below stands in for the customer mask contents.
`timescale 1ns/1ps
module meb_rom (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [11:0] addr,
	output logic      [7:0]  rdata_r
);
	import meb_pkg::*;

	logic [7:0] rdata_nxt;

	always_comb begin
		rdata_nxt = addr[7:0] ^ {addr[11:8], addr[11:8]};
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

endmodule // meb_rom

// ===== verilog/meb_bus.sv
// Purpose: External memory bus sequencer with strobes and ROM verification.
// Assumes: clk is the oscillator; all pins are asynchronous to it.
// Notes: Pin inputs pass two flip-flops, so samples lag the pins by two cycles.
`timescale 1ns/1ps
module meb_bus (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              reset_standby_pin,
	input  wire logic              external_fetch_select,
	input  wire logic              ale_i,
	output logic                   ale_o,
	output logic                   ale_oe,
	input  wire logic              program_store_strobe_n_i,
	output logic                   program_store_strobe_n_o,
	output logic                   program_store_strobe_n_oe,
	input  wire logic [7:0]        mux_addr_data_port_i,
	output meb_pkg::meb_port_t     mux_addr_data_port,
	input  wire logic [7:0]        verify_low_address_port_i,
	input  wire logic [7:0]        high_address_port_i,
	output meb_pkg::meb_port_t     high_address_port,
	output logic      [7:0]        alt_function_port_o,
	input  wire logic [7:0]        port2_latch,
	input  wire logic [7:0]        port3_latch,
	input  wire logic              req_valid,
	input  wire meb_pkg::meb_req_t req,
	output logic                   req_ready,
	output logic                   resp_valid,
	output meb_pkg::meb_resp_t     resp,
	output logic                   in_reset,
	output logic                   verify_mode
);
	import meb_pkg::*;

	meb_pins_t  pins_raw;
	meb_pins_t  pins_meta_r;
	meb_pins_t  pins_sync_r;
	logic       hold;
	logic       take;
	logic       verify_nxt;
	logic       verify_r;
	logic [2:0] phase_nxt;
	logic [2:0] phase_r;
	meb_slot_t  slot_nxt;
	meb_slot_t  slot_r;
	logic [15:0] addr_nxt;
	logic [15:0] addr_r;
	logic [7:0] wdata_nxt;
	logic [7:0] wdata_r;
	logic       is_wr_nxt;
	logic       is_wr_r;
	logic       resp_valid_nxt;
	logic       resp_valid_r;
	meb_resp_t  resp_nxt;
	meb_resp_t  resp_r;
	logic       ale_nxt;
	logic       ale_r;
	logic       program_store_strobe_n_n_nxt;
	logic       program_store_strobe_n_n_r;
	logic       rd_n_nxt;
	logic       rd_n_r;
	logic       wr_n_nxt;
	logic       wr_n_r;
	meb_port_t  p0_nxt;
	meb_port_t  p0_r;
	meb_port_t  p2_nxt;
	meb_port_t  p2_r;
	logic       ext_nxt;
	logic [11:0] rom_addr;
	logic [7:0] rom_rdata;

	assign pins_raw = '{rst: reset_standby_pin, ea: external_fetch_select, ale: ale_i,
		program_store_strobe_n_n: program_store_strobe_n_i, p0: mux_addr_data_port_i,
		p1: verify_low_address_port_i, p2: high_address_port_i};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pins_meta_r <= '0;
			pins_sync_r <= '0;
		end else begin
			pins_meta_r <= pins_raw;
			pins_sync_r <= pins_meta_r;
		end
	end

	assign hold = pins_sync_r.rst;
	// A new request starts only at a slot boundary; the data slot must follow its address slot.
	assign req_ready = !hold && (phase_r == MEB_PH_LAST) && (slot_r != MEB_SLOT_DADDR);
	assign take = req_valid && req_ready;

	assign rom_addr = verify_r ? {pins_sync_r.p2[3:0], pins_sync_r.p1} : addr_r[11:0];

	meb_rom u_rom (
		.clk     (clk),
		.reset_n (reset_n),
		.addr    (rom_addr),
		.rdata_r (rom_rdata)
	);

	always_comb begin
		// rest in last phase
		// Resting in the last phase gives the first latch strobe after any reset its full width.
		phase_nxt      = hold ? MEB_PH_LAST : (phase_r == MEB_PH_LAST) ? 3'h0 : phase_r + 3'h1;
		slot_nxt       = slot_r;
		addr_nxt       = addr_r;
		wdata_nxt      = wdata_r;
		is_wr_nxt      = is_wr_r;
		resp_valid_nxt = 1'b0;
		resp_nxt       = resp_r;
		verify_nxt = hold && pins_sync_r.ea && pins_sync_r.ale && !pins_sync_r.program_store_strobe_n_n
			&& (pins_sync_r.p2[6:4] == MEB_VERIFY_P2);
		if (hold) begin
			slot_nxt = MEB_SLOT_IDLE;
		end else if (phase_r == MEB_PH_LAST) begin
			if (slot_r == MEB_SLOT_IFETCH) begin
				resp_valid_nxt = 1'b1;
				resp_nxt       = '{is_code: 1'b1, data: rom_rdata};
			end else if (slot_r == MEB_SLOT_XFETCH || slot_r == MEB_SLOT_DRD) begin
				resp_valid_nxt = 1'b1;
				resp_nxt       = '{is_code: slot_r == MEB_SLOT_XFETCH, data: pins_sync_r.p0};
			end
			if (slot_r == MEB_SLOT_DADDR) begin
				slot_nxt = is_wr_r ? MEB_SLOT_DWR : MEB_SLOT_DRD;
			end else if (take) begin
				addr_nxt  = req.addr;
				wdata_nxt = req.wdata;
				is_wr_nxt = (req.op == MEB_OP_WRITE);
				if (req.op == MEB_OP_FETCH) begin
					if (pins_sync_r.ea && req.addr < MEB_ROM_LIMIT) begin
						slot_nxt = MEB_SLOT_IFETCH;
					end else begin
						slot_nxt = MEB_SLOT_XFETCH;
					end
				end else begin
					slot_nxt = MEB_SLOT_DADDR;
				end
			end else begin
				slot_nxt = MEB_SLOT_IDLE;
			end
		end
	end

	always_comb begin
		ext_nxt = (slot_nxt == MEB_SLOT_XFETCH) || (slot_nxt == MEB_SLOT_DADDR)
			|| (slot_nxt == MEB_SLOT_DRD) || (slot_nxt == MEB_SLOT_DWR);
		ale_nxt = !hold && (phase_nxt < MEB_ALE_END)
			&& (slot_nxt != MEB_SLOT_DRD) && (slot_nxt != MEB_SLOT_DWR);
		program_store_strobe_n_n_nxt = !((slot_nxt == MEB_SLOT_XFETCH) && (phase_nxt >= MEB_PROGRAM_STORE_STROBE_N_START)
			&& (phase_nxt < MEB_PROGRAM_STORE_STROBE_N_END));
		rd_n_nxt = !((slot_nxt == MEB_SLOT_DRD) && (phase_nxt < MEB_RD_END));
		wr_n_nxt = !((slot_nxt == MEB_SLOT_DWR) && (phase_nxt >= MEB_WR_START)
			&& (phase_nxt < MEB_WR_END));
		p0_nxt = '{o: 8'h00, oe: 8'h00};
		if (verify_nxt) begin
			p0_nxt = '{o: rom_rdata, oe: 8'hff};
		end else if ((slot_nxt == MEB_SLOT_XFETCH || slot_nxt == MEB_SLOT_DADDR)
			&& phase_nxt < MEB_ADDR_END) begin
			p0_nxt = '{o: addr_nxt[7:0], oe: 8'hff};
		end else if (slot_nxt == MEB_SLOT_DWR) begin
			p0_nxt = '{o: wdata_nxt, oe: 8'hff};
		end
		p2_nxt = '{o: ext_nxt ? addr_nxt[15:8] : port2_latch, oe: {8{!hold}}};
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_r      <= MEB_PH_LAST;
			slot_r       <= MEB_SLOT_IDLE;
			addr_r       <= 16'h0000;
			wdata_r      <= 8'h00;
			is_wr_r      <= 1'b0;
			resp_valid_r <= 1'b0;
			resp_r       <= '0;
			verify_r     <= 1'b0;
			ale_r        <= 1'b0;
			program_store_strobe_n_n_r     <= 1'b1;
			rd_n_r       <= 1'b1;
			wr_n_r       <= 1'b1;
			p0_r         <= '0;
			p2_r         <= '{o: MEB_LATCH_RESET, oe: 8'h00};
		end else begin
			phase_r      <= phase_nxt;
			slot_r       <= slot_nxt;
			addr_r       <= addr_nxt;
			wdata_r      <= wdata_nxt;
			is_wr_r      <= is_wr_nxt;
			resp_valid_r <= resp_valid_nxt;
			resp_r       <= resp_nxt;
			verify_r     <= verify_nxt;
			ale_r        <= ale_nxt;
			program_store_strobe_n_n_r     <= program_store_strobe_n_n_nxt;
			rd_n_r       <= rd_n_nxt;
			wr_n_r       <= wr_n_nxt;
			p0_r         <= p0_nxt;
			p2_r         <= p2_nxt;
		end
	end

	// Latch and program strobe pins float while the reset pin is high so a tester can drive them for verification.
	assign ale_o                     = ale_r;
	assign ale_oe                    = !hold;
	assign program_store_strobe_n_o  = program_store_strobe_n_n_r;
	assign program_store_strobe_n_oe = !hold;
	assign mux_addr_data_port        = p0_r;
	assign high_address_port         = p2_r;
	assign resp_valid                = resp_valid_r;
	assign resp                      = resp_r;
	assign in_reset                  = hold;
	assign verify_mode               = verify_r;

	always_comb begin
		alt_function_port_o    = port3_latch;
		alt_function_port_o[6] = port3_latch[6] & wr_n_r;
		alt_function_port_o[7] = port3_latch[7] & rd_n_r;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	ale_width_a: assert property ($rose(ale_o) |=> ale_o ##1 !ale_o)
		else $error("Latch strobe width is not two cycles.");
	ale_skip_data_a: assert property ((slot_r == MEB_SLOT_DRD || slot_r == MEB_SLOT_DWR)
		|-> !ale_o)
		else $error("Latch strobe seen in data slot.");
	program_store_strobe_n_width_a: assert property ($fell(program_store_strobe_n_o)
		|-> (!program_store_strobe_n_o)[*3] ##1 program_store_strobe_n_o)
		else $error("Program strobe width is not three cycles.");
	program_store_strobe_n_internal_a: assert property ((slot_r != MEB_SLOT_XFETCH)
		|-> program_store_strobe_n_o)
		else $error("Program strobe low outside external fetch.");
	addr_float_a: assert property ((!program_store_strobe_n_o || !rd_n_r)
		|-> mux_addr_data_port.oe == 8'h00)
		else $error("Mux port driven during read strobe.");
	high_addr_a: assert property ((slot_r == MEB_SLOT_XFETCH || slot_r == MEB_SLOT_DRD)
		|-> high_address_port.o == addr_r[15:8] && high_address_port.oe == 8'hff)
		else $error("High address port not carrying upper address.");
	wr_data_a: assert property ($fell(wr_n_r) |-> mux_addr_data_port.o == wdata_r
		&& mux_addr_data_port.oe == 8'hff ##3 wr_n_r)
		else $error("Write strobe without data or wrong width.");
	alt_latch_a: assert property (!port3_latch[7] |-> !alt_function_port_o[7])
		else $error("Read pin left its latch value.");
	reset_hold_a: assert property (hold |-> !req_ready ##1 !resp_valid)
		else $error("Activity while reset pin is high.");
	verify_out_a: assert property (verify_r |-> mux_addr_data_port.oe == 8'hff)
		else $error("Verify data not driven.");
	fetch_sel_a: assert property ((take && req.op == MEB_OP_FETCH && !pins_sync_r.ea)
		|=> slot_r == MEB_SLOT_XFETCH)
		else $error("Fetch not external with select low.");

	ext_fetch_c: cover property (slot_r == MEB_SLOT_XFETCH ##6 slot_r == MEB_SLOT_XFETCH);
	data_read_c: cover property (slot_r == MEB_SLOT_DRD && resp_valid_nxt);
	data_write_c: cover property ($rose(wr_n_r));
	verify_c: cover property ($rose(verify_mode));

endmodule // meb_bus

// ===== verif/meb_mem_model.sv
// Purpose: External program and data memory with its address latch.
// Assumes: The device drive wins the port; otherwise this memory or a float.
// Notes: A floating port shows the inverse of its last level, never a held value.
`timescale 1ns/1ps
module meb_mem_model (
	input  wire logic               clk,
	input  wire logic               ale,
	input  wire logic               program_store_strobe_n_n,
	input  wire logic               rd_n,
	input  wire logic               wr_n,
	input  wire logic [7:0]         addr_hi,
	input  wire meb_pkg::meb_port_t dev,
	output logic      [7:0]         pin
);
	import meb_pkg::*;
	logic [7:0] lat_r;
	logic [7:0] last_r;
	logic [7:0] dmem [256];
	initial begin
		for (int i = 0; i < 256; i++) begin
			dmem[i] = ~i[7:0];
		end
	end
	assign pin = dev.oe[0] ? dev.o : !program_store_strobe_n_n ? (lat_r ^ addr_hi ^ 8'h5a) :
		!rd_n ? dmem[lat_r] : ~last_r;
	always @(posedge clk) begin
		last_r <= pin;
		if (ale) begin
			lat_r <= pin;
		end
		if (!wr_n) begin
			dmem[lat_r] <= pin;
		end
	end
endmodule // meb_mem_model

// ===== verif/mcu_external_memory_bus_bench.sv
// Purpose: Random and corner traffic through the bus sequencer.
// Assumes: Strobe latch bits stay set while the random traffic runs.
// Notes: Expected bytes are worked out here from the memory patterns.
`timescale 1ns/1ps
module mcu_external_memory_bus_bench;
	import meb_pkg::*;
	logic clk = 0, reset_n, rsp, ea, ale_tb, program_store_strobe_n_tb, req_valid, req_ready, resp_valid;
	logic in_reset, verify_mode, ale_o, ale_oe, ps_o, ps_oe;
	logic [7:0] p1, p2_tb, p2l, p3, alt, p0_pin, sh [256];
	meb_req_t   req;
	meb_resp_t  resp;
	meb_port_t  mux, hi;
	int         errors = 0, n_compared = 0, seed, cyc = 0, npx = 0, npd = 0, nrx = 0, nrd = 0;
	wire        ale_pin  = ale_oe ? ale_o : ale_tb;
	wire        program_store_strobe_n_pin = ps_oe ? ps_o : program_store_strobe_n_tb;
	wire [7:0]  p2_pin   = hi.oe[0] ? hi.o : p2_tb;
	meb_bus u_meb_bus (.clk(clk), .reset_n(reset_n), .reset_standby_pin(rsp),
		.external_fetch_select(ea), .ale_i(ale_pin), .ale_o(ale_o), .ale_oe(ale_oe),
		.program_store_strobe_n_i(program_store_strobe_n_pin), .program_store_strobe_n_o(ps_o),
		.program_store_strobe_n_oe(ps_oe), .mux_addr_data_port_i(p0_pin),
		.mux_addr_data_port(mux), .verify_low_address_port_i(p1),
		.high_address_port_i(p2_pin), .high_address_port(hi), .alt_function_port_o(alt),
		.port2_latch(p2l), .port3_latch(p3), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .resp_valid(resp_valid), .resp(resp), .in_reset(in_reset),
		.verify_mode(verify_mode));
	meb_mem_model u_meb_mem_model (.clk(clk), .ale(ale_pin), .program_store_strobe_n_n(program_store_strobe_n_pin),
		.rd_n(alt[7]), .wr_n(alt[6]), .addr_hi(p2_pin), .dev(mux), .pin(p0_pin));
	always #10 clk = ~clk;
	always @(negedge ps_o) npd++;
	always @(negedge alt[7]) nrd++;
	task complete_run;
		if (errors == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			errors++;
			complete_run;
		end
	end
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic op(input meb_op_t k, input logic [15:0] a, input logic [7:0] d);
		int n;
		logic [7:0] x;
		n = 0;
		req_valid <= 1'b1;
		req <= '{k, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (!req_ready && n < 40);
		if (!req_ready) errors++;
		req_valid <= 1'b0;
		x = (!ea || a >= MEB_ROM_LIMIT) ? a[7:0] ^ a[15:8] ^ 8'h5a : a[7:0] ^ {2{a[11:8]}};
		if (k == MEB_OP_FETCH && x == (a[7:0] ^ a[15:8] ^ 8'h5a) && (!ea || a[15:12] != 0))
			npx++;
		if (k == MEB_OP_WRITE) begin
			sh[a[7:0]] = d;
			repeat (12) @(posedge clk);
		end else begin
			if (k == MEB_OP_READ) begin
				x = sh[a[7:0]];
				nrx++;
			end
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (!resp_valid && n < 30);
			if (!resp_valid) errors++;
			chk("resp data", resp.data, x);
			chk("resp kind", resp.is_code, k == MEB_OP_FETCH);
		end
		chk("alt port", alt, p3);
	endtask
	initial begin
		logic [31:0] r;
		seed = 77;
		{rsp, ale_tb, program_store_strobe_n_tb, req_valid, reset_n, ea} = 6'b011001;
		{p1, p2_tb, p2l, p3, req} = '0;
		p3 = 8'hff;
		for (int i = 0; i < 256; i++) sh[i] = ~i[7:0];
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		op(MEB_OP_FETCH, 16'h0fff, 8'h00);
		op(MEB_OP_FETCH, 16'h1000, 8'h00);
		for (int i = 0; i < 60; i++) begin
			r = $random(seed);
			if (i % 15 == 0) begin
				ea <= r[20];
				repeat (4) @(posedge clk);
			end
			p3 <= r[31:24] | 8'hc0;
			p2l <= r[23:16];
			if (r[1:0] == 2'h0 || r[1:0] == 2'h3) op(MEB_OP_FETCH, r[17:2], 8'h00);
			else op(meb_op_t'(r[1:0]), {r[17:10], 4'h0, r[5:2]}, r[25:18]);
		end
		chk("program_store_strobe_n pulses", 16'(npd), 16'(npx));
		chk("read strobes", 16'(nrd), 16'(nrx));
		p3 <= 8'h7f;
		op(MEB_OP_READ, 16'h2a05, 8'h00);
		p3 <= 8'hff;
		ea <= 1'b1;
		rsp <= 1'b1;
		program_store_strobe_n_tb <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			r = $random(seed);
			p1 <= r[7:0];
			p2_tb <= {4'h0, r[11:8]};
			repeat (12) @(posedge clk);
			chk("in reset", {in_reset, verify_mode, ale_oe, ps_oe}, 4'hc);
			chk("verify data", mux, {r[7:0] ^ {2{r[11:8]}}, 8'hff});
		end
		rsp <= 1'b0;
		program_store_strobe_n_tb <= 1'b1;
		repeat (8) @(posedge clk);
		chk("reset left", in_reset, 1'b0);
		op(MEB_OP_FETCH, 16'h8421, 8'h00);
		complete_run;
	end
endmodule // mcu_external_memory_bus_bench
